// ---- include/pulse_ramp_pkg.sv ----
// Constants, register map and state types of the two-channel pulse ramp generator
package pulse_ramp_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int PERIOD_MS = 4;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * PERIOD_MS;
	localparam int PERIODS_PER_S = 1000 / PERIOD_MS;
	localparam logic [31:0] TARGET_MAX = 32'h000186a0;
	localparam logic [15:0] RATE_MIN = 16'h0001;
	localparam logic [15:0] PORT_CH0 = 16'h0000;
	localparam logic [15:0] PORT_CH1 = 16'h0001;
	localparam logic [15:0] MODE_MAX = 16'h0003;
	localparam int MODE_DIR_BIT = 0;
	localparam int MODE_CONT_BIT = 1;
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_PORT = 12'h004;
	localparam logic [11:0] OFF_MODE = 12'h008;
	localparam logic [11:0] OFF_RATE = 12'h00c;
	localparam logic [11:0] OFF_TGT_LO = 12'h010;
	localparam logic [11:0] OFF_TGT_HI = 12'h014;
	localparam logic [11:0] OFF_PCOUNT = 12'h018;
	localparam logic [11:0] OFF_DECEL = 12'h01c;
	localparam logic [11:0] OFF_CMD = 12'h020;
	localparam logic [11:0] OFF_STATUS = 12'h024;
	localparam logic [11:0] OFF_FREQ0 = 12'h028;
	localparam logic [11:0] OFF_FREQ1 = 12'h02c;
	localparam logic [11:0] OFF_POS0 = 12'h030;
	localparam logic [11:0] OFF_POS1 = 12'h034;
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_RELAY_BIT = 1;
	localparam int CTRL_CYCLIC_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h1;
	localparam int CMD_ACCEL_BIT = 0;
	localparam int CMD_POSN_BIT = 1;
	localparam int CMD_COUNT_BIT = 2;
	localparam int CMD_STOP_BIT = 3;
	localparam int CMD_ORG_START_BIT = 4;
	localparam int CMD_ORG_DONE_BIT = 5;
	localparam int CMD_ABS_BIT = 8;
	localparam int CMD_IRQ_BIT = 9;
	typedef struct packed {
		logic busy;
		logic cont;
		logic dir;
		logic zero_stop;
		logic [31:0] cur;
		logic [31:0] target;
		logic [15:0] accel;
		logic [15:0] decel;
		logic [31:0] remain;
		logic [31:0] pos;
		logic origin_ok;
		logic origin_busy;
		logic cnt_loaded;
		logic cnt_abs;
		logic [31:0] cnt;
	} chan_t;
endpackage

// ---- verilog/freq_step_gen.sv ----
// Phase accumulator that turns a frequency in hertz into one-cycle step events
`timescale 1ns/1ps
module freq_step_gen
	import pulse_ramp_pkg::*;
(
	input wire logic pclk, // System clock
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic en, // Channel is emitting
	input wire logic [31:0] freq, // Present frequency in Hz
	output logic step // One-cycle pulse event
);
	typedef struct packed {
		logic [31:0] acc;
		logic step;
	} nco_t;

	nco_t r, n;
	logic [32:0] sum;

	always_comb
	begin
		n = r;
		sum = {1'b0, r.acc} + {1'b0, freq};
		n.step = 1'b0;
		if (!en)
		begin
			n.acc = '0;
		end
		else if (sum >= 33'(CLK_HZ))
		begin
			n.acc = 32'(sum - 33'(CLK_HZ));
			n.step = 1'b1;
		end
		else
		begin
			n.acc = sum[31:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r <= '0;
		else
			r <= n;
	end

	assign step = r.step;
endmodule

// ---- verilog/pulse_ramp_generator.sv ----
// Two-channel pulse ramp generator with APB register access
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module pulse_ramp_generator
	import pulse_ramp_pkg::*;
#(
	parameter int TICK = TICK_CYCLES
)
(
	input wire logic pclk, // System clock, 50 MHz
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	output logic [1:0] pulse_out, // Pulse train per channel
	output logic [1:0] dir_out // Direction per channel, 1 is reverse
);
	import pulse_ramp_pkg::*;

	typedef struct packed {
		chan_t [1:0] ch;
		logic [2:0] ctrl;
		logic [15:0] port;
		logic [15:0] mode;
		logic [15:0] rate;
		logic [15:0] tgt_lo;
		logic [15:0] tgt_hi;
		logic [31:0] pcount;
		logic [15:0] decel;
		logic err;
		logic [31:0] tick_cnt;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [1:0] pulse;
		logic [1:0] dir;
	} state_t;

	state_t r, n;
	logic [1:0] step;
	logic [31:0] tgt;
	logic tick;
	logic wr_go;
	logic rd_go;
	logic port_bad;
	logic op_bad;
	logic e;
	logic sel;
	logic [32:0] move;
	logic [31:0] dn;

	// Distance needed to stop from cur at rate dec, compared with what remains
	function automatic logic need_decel(input logic [31:0] cur, input logic [31:0] rem, input logic [15:0] dec);
		logic [63:0] lhs;
		logic [63:0] rhs;
		lhs = 64'(cur) * 64'(cur);
		rhs = 64'(rem) * 64'(dec) * 64'(2 * PERIODS_PER_S);
		return lhs >= rhs;
	endfunction

	// Returns {direction, pulse count} for a relative or absolute count
	function automatic logic [32:0] plan_move(input logic [31:0] cnt, input logic absm, input logic mdir,
		input logic [31:0] pos);
		logic [31:0] delta;
		delta = cnt - pos;
		if (!absm)
			return {mdir, cnt};
		else if (delta[31])
			return {1'b1, 32'(-delta)};
		else
			return {1'b0, delta};
	endfunction

	function automatic logic mapped(input logic [11:0] a);
		return a == OFF_CTRL || a == OFF_PORT || a == OFF_MODE || a == OFF_RATE || a == OFF_TGT_LO
			|| a == OFF_TGT_HI || a == OFF_PCOUNT || a == OFF_DECEL || a == OFF_CMD || a == OFF_STATUS
			|| a == OFF_FREQ0 || a == OFF_FREQ1 || a == OFF_POS0 || a == OFF_POS1;
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_gen
			freq_step_gen u_gen (
				.pclk(pclk),
				.presetn(presetn),
				.en(r.ch[gi].busy),
				.freq(r.ch[gi].cur),
				.step(step[gi])
			);
		end
	endgenerate

	always_comb
	begin
		n = r;
		n.pulse = '0;
		tgt = {r.tgt_hi, r.tgt_lo};
		wr_go = psel && penable && r.pready && pwrite;
		rd_go = psel && penable && !r.pready && !pwrite;
		tick = r.tick_cnt >= 32'(TICK - 1);
		n.tick_cnt = tick ? 32'h00000000 : r.tick_cnt + 32'h00000001;
		port_bad = r.port != PORT_CH0 && r.port != PORT_CH1;
		op_bad = port_bad || r.mode > MODE_MAX || r.rate < RATE_MIN || tgt > TARGET_MAX;
		sel = r.port == PORT_CH1;
		e = 1'b0;
		move = '0;
		dn = '0;

		for (int c = 0; c < 2; c++)
		begin
			if (r.ch[c].busy && step[c])
			begin
				n.pulse[c] = 1'b1;
				n.ch[c].pos = r.ch[c].dir ? r.ch[c].pos - 32'h00000001 : r.ch[c].pos + 32'h00000001;
				if (!r.ch[c].cont)
				begin
					n.ch[c].remain = r.ch[c].remain - 32'h00000001;
					if (r.ch[c].remain <= 32'h00000001)
					begin
						n.ch[c].busy = 1'b0;
						n.ch[c].cur = '0;
					end
				end
			end
			// A channel that has just emitted its last pulse keeps its cleared frequency
			if (r.ch[c].busy && n.ch[c].busy && tick)
			begin
				if (!r.ch[c].cont && need_decel(r.ch[c].cur, r.ch[c].remain, r.ch[c].decel))
				begin
					// Floor at one rate step so the last pulses still come out
					dn = r.ch[c].cur - 32'(r.ch[c].decel);
					n.ch[c].cur = r.ch[c].cur > 32'(r.ch[c].decel) * 2 ? dn : 32'(r.ch[c].decel);
				end
				else if (r.ch[c].cur < r.ch[c].target)
				begin
					if (r.ch[c].target - r.ch[c].cur > 32'(r.ch[c].accel))
						n.ch[c].cur = r.ch[c].cur + 32'(r.ch[c].accel);
					else
						n.ch[c].cur = r.ch[c].target;
				end
				else if (r.ch[c].cur > r.ch[c].target)
				begin
					if (r.ch[c].cur - r.ch[c].target > 32'(r.ch[c].decel))
						n.ch[c].cur = r.ch[c].cur - 32'(r.ch[c].decel);
					else
						n.ch[c].cur = r.ch[c].target;
					if (r.ch[c].cont && r.ch[c].target == 32'h00000000 && r.ch[c].cur <= 32'(r.ch[c].decel))
					begin
						n.ch[c].busy = 1'b0;
						n.ch[c].cur = '0;
					end
				end
			end
		end

		if (wr_go)
		begin
			case (paddr)
				OFF_CTRL: n.ctrl = pwdata[2:0];
				OFF_PORT: n.port = pwdata[15:0];
				OFF_MODE: n.mode = pwdata[15:0];
				OFF_RATE: n.rate = pwdata[15:0];
				OFF_TGT_LO: n.tgt_lo = pwdata[15:0];
				OFF_TGT_HI: n.tgt_hi = pwdata[15:0];
				OFF_PCOUNT: n.pcount = pwdata;
				OFF_DECEL: n.decel = pwdata[15:0];
				default: n.err = r.err;
			endcase
		end

		if (wr_go && paddr == OFF_CMD)
		begin
			if (pwdata[CMD_COUNT_BIT])
			begin
				n.err = port_bad;
				if (!port_bad)
				begin
					n.ch[sel].cnt = r.pcount;
					n.ch[sel].cnt_abs = pwdata[CMD_ABS_BIT];
					n.ch[sel].cnt_loaded = 1'b1;
				end
			end
			if (pwdata[CMD_STOP_BIT] && !port_bad)
			begin
				n.ch[sel].busy = 1'b0;
				n.ch[sel].cur = '0;
			end
			if (pwdata[CMD_ORG_START_BIT] && !port_bad)
				n.ch[sel].origin_busy = 1'b1;
			if (pwdata[CMD_ORG_DONE_BIT] && !port_bad)
			begin
				n.ch[sel].origin_busy = 1'b0;
				n.ch[sel].origin_ok = 1'b1;
				n.ch[sel].pos = '0;
			end
			// Relay variant skips both ramp commands entirely
			if (pwdata[CMD_ACCEL_BIT] && !r.ctrl[CTRL_RELAY_BIT])
			begin
				e = op_bad;
				if (!port_bad)
				begin
					e = e || r.ch[sel].origin_busy;
					e = e || (r.ch[sel].busy && r.mode[MODE_CONT_BIT] != r.ch[sel].cont);
					e = e || (pwdata[CMD_IRQ_BIT] && r.ctrl[CTRL_CYCLIC_BIT]);
					e = e || (!r.mode[MODE_CONT_BIT] && r.ch[sel].cnt_loaded && r.ch[sel].cnt_abs
						&& !r.ch[sel].origin_ok);
				end
				n.err = e;
				if (!e && !(r.ch[sel].busy && r.ch[sel].zero_stop))
				begin
					n.ch[sel].cont = r.mode[MODE_CONT_BIT];
					n.ch[sel].accel = r.rate;
					n.ch[sel].decel = r.rate;
					n.ch[sel].target = tgt;
					n.ch[sel].zero_stop = tgt == 32'h00000000;
					if (r.mode[MODE_CONT_BIT])
					begin
						n.ch[sel].dir = r.mode[MODE_DIR_BIT];
						n.ch[sel].busy = r.ch[sel].busy || tgt != 32'h00000000;
					end
					else
					begin
						// Count must be reloaded before every independent start
						move = plan_move(r.ch[sel].cnt, r.ch[sel].cnt_abs, r.mode[MODE_DIR_BIT], r.ch[sel].pos);
						n.ch[sel].dir = move[32];
						n.ch[sel].remain = move[31:0];
						n.ch[sel].busy = r.ch[sel].cnt_loaded && move[31:0] != 32'h00000000;
						n.ch[sel].cnt_loaded = 1'b0;
					end
				end
			end
			else if (pwdata[CMD_POSN_BIT] && !r.ctrl[CTRL_RELAY_BIT])
			begin
				e = op_bad;
				if (!port_bad)
				begin
					e = e || r.ch[sel].origin_busy;
					e = e || (pwdata[CMD_IRQ_BIT] && r.ctrl[CTRL_CYCLIC_BIT]);
					e = e || (pwdata[CMD_ABS_BIT] && !r.ch[sel].origin_ok);
				end
				n.err = e;
				if (!e && !(r.ch[sel].busy && r.ch[sel].zero_stop))
				begin
					// Takeover keeps the present frequency
					move = plan_move(r.pcount, pwdata[CMD_ABS_BIT], r.mode[MODE_DIR_BIT], r.ch[sel].pos);
					n.ch[sel].cont = 1'b0;
					n.ch[sel].dir = move[32];
					n.ch[sel].remain = move[31:0];
					n.ch[sel].accel = r.rate;
					n.ch[sel].decel = r.decel == 16'h0000 ? r.rate : r.decel;
					n.ch[sel].target = tgt;
					n.ch[sel].zero_stop = tgt == 32'h00000000;
					n.ch[sel].busy = move[31:0] != 32'h00000000;
					if (move[31:0] == 32'h00000000)
						n.ch[sel].cur = '0;
				end
			end
		end

		if (!r.ctrl[CTRL_RUN_BIT])
		begin
			for (int c = 0; c < 2; c++)
			begin
				n.ch[c].busy = 1'b0;
				n.ch[c].cur = '0;
			end
			n.pulse = '0;
		end

		for (int c = 0; c < 2; c++)
			n.dir[c] = n.ch[c].dir;

		n.pready = psel && penable && !r.pready;
		n.pslverr = psel && penable && !r.pready && !mapped(paddr);
		if (rd_go)
		begin
			case (paddr)
				OFF_CTRL: n.prdata = {29'h00000000, r.ctrl};
				OFF_PORT: n.prdata = {16'h0000, r.port};
				OFF_MODE: n.prdata = {16'h0000, r.mode};
				OFF_RATE: n.prdata = {16'h0000, r.rate};
				OFF_TGT_LO: n.prdata = {16'h0000, r.tgt_lo};
				OFF_TGT_HI: n.prdata = {16'h0000, r.tgt_hi};
				OFF_PCOUNT: n.prdata = r.pcount;
				OFF_DECEL: n.prdata = {16'h0000, r.decel};
				OFF_STATUS: n.prdata = {23'h000000, r.ch[1].cnt_loaded, r.ch[0].cnt_loaded, r.ch[1].origin_busy,
					r.ch[0].origin_busy, r.ch[1].origin_ok, r.ch[0].origin_ok, r.ch[1].busy, r.ch[0].busy, r.err};
				OFF_FREQ0: n.prdata = r.ch[0].cur;
				OFF_FREQ1: n.prdata = r.ch[1].cur;
				OFF_POS0: n.prdata = r.ch[0].pos;
				OFF_POS1: n.prdata = r.ch[1].pos;
				default: n.prdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r <= '0;
			r.ctrl <= CTRL_RESET;
		end
		else
		begin
			r <= n;
		end
	end

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign pulse_out = r.pulse;
	assign dir_out = r.dir;
endmodule

// ---- tb/motor_drive_model.sv ----
// Motor drive stand-in that counts the pulses it takes on each channel
`timescale 1ns/1ps
module motor_drive_model
(
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic [1:0] pulse_out, // Pulse trains
	input wire logic [1:0] dir_out, // Directions, unused by the counters
	output logic [31:0] c0, // Pulses on channel 0
	output logic [31:0] c1 // Pulses on channel 1
);
	// Both channels are read with one pulse method, a one-cycle high level
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			c0 <= 32'h0;
			c1 <= 32'h0;
		end
		else
		begin
			c0 <= c0 + {31'h0, pulse_out[0]};
			c1 <= c1 + {31'h0, pulse_out[1]};
		end
	end
endmodule

// ---- tb/pulse_ramp_sva.sv ----
// Port-level checker of the pulse ramp generator
`timescale 1ns/1ps
module pulse_ramp_sva
	import pulse_ramp_pkg::*;
(
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [11:0] paddr, // APB address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [31:0] prdata, // APB read data
	input wire logic pready, // APB ready
	input wire logic pslverr, // APB error
	input wire logic [1:0] pulse_out, // Pulse trains
	input wire logic [1:0] dir_out // Directions
);
	wire logic wc = psel && penable && pready && pwrite && (paddr == OFF_CMD || paddr == OFF_CTRL);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_one_wait: assert property ($rose(psel && penable) |-> !pready ##1 pready)
		else $error("ready not after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_qual: assert property (pslverr |-> pready && psel && penable)
		else $error("error outside an access");
	a_unmapped_err: assert property (psel && penable && pready && paddr > OFF_POS1 |-> pslverr)
		else $error("unmapped access without error");
	a_mapped_ok: assert property (pready && paddr <= OFF_POS1 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped access with error");
	a_unmapped_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_gap_ch0: assert property (pulse_out[0] |=> !pulse_out[0] [*8])
		else $error("channel 0 pulses too close");
	a_gap_ch1: assert property (pulse_out[1] |=> !pulse_out[1] [*8])
		else $error("channel 1 pulses too close");
	a_run_stop: assert property (wc && paddr == OFF_CTRL && !pwdata[0] |-> ##2 (pulse_out == 2'h0) [*8])
		else $error("pulses after leaving run mode");
	a_dir_cause: assert property ($changed(dir_out) |-> $past(wc) || $past(wc, 2) || $past(wc, 3))
		else $error("direction changed without a command");
endmodule

bind pulse_ramp_generator pulse_ramp_sva u_pulse_ramp_sva (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .pulse_out, .dir_out);

// ---- tb/tb_top.sv ----
// Register-level testbench of the pulse ramp generator
`timescale 1ns/1ps
module tb_top;
	import pulse_ramp_pkg::*;
	localparam logic [31:0] F = 32'h186a0;
	localparam logic [31:0] R = 32'h61a8;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, s, c0, c1;
	logic [1:0] pulse_out, dir_out;
	int bad_count, checks_done, cyc, i;
	pulse_ramp_generator #(.TICK(50)) u_pulse_ramp_generator (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pulse_out, .dir_out);
	motor_drive_model u_motor_drive_model (.pclk, .presetn, .pulse_out, .dir_out, .c0, .c1);
	initial
	begin
		pclk = 0;
		forever #10 pclk = ~pclk;
	end
	task stop_test;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 90000)
		begin
			bad_count++;
			stop_test;
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Request stands until pready is seen high at a rising edge; read data is taken at that edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			bad_count++;
		q = prdata;
		psel <= 0;
		penable <= 0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task cfg(input logic [31:0] p, input logic [31:0] m, input logic [31:0] r, input logic [31:0] t);
		wr(OFF_PORT, p);
		wr(OFF_MODE, m);
		wr(OFF_RATE, r);
		wr(OFF_TGT_LO, {16'h0, t[15:0]});
		wr(OFF_TGT_HI, {16'h0, t[31:16]});
	endtask
	task err(input logic e);
		rd(OFF_STATUS);
		chk(q & 32'h1, {31'h0, e});
	endtask
	task wi(input int b);
		int n;
		n = 0;
		do
		begin
			rd(OFF_STATUS);
			n++;
		end
		while (q[b] !== 1'b0 && n < 12000);
		if (q[b] !== 1'b0)
			bad_count++;
	endtask
	initial
	begin
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 12'h0;
		pwdata = 32'h0;
		bad_count = 0;
		checks_done = 0;
		cyc = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1;
		rd(OFF_CTRL);
		chk(q, 32'h1);
		rd(OFF_STATUS);
		chk(q, 32'h0);
		rd(12'h100);
		chk(q, 32'h0);
		for (i = 0; i < 4; i++)
		begin
			cfg(i == 0 ? 2 : 1, i == 1 ? 4 : 2, i == 2 ? 0 : R, i == 3 ? F + 1 : F);
			wr(OFF_CMD, 32'h1);
			err(1'b1);
		end
		cfg(1, 2, R, F);
		wr(OFF_CMD, 32'h1);
		err(1'b0);
		repeat (600) @(posedge pclk);
		rd(OFF_FREQ1);
		chk(q, F);
		chk(c0, 32'h0);
		cfg(1, 0, R, F);
		wr(OFF_CMD, 32'h1);
		err(1'b1);
		wr(OFF_CTRL, 32'h5);
		cfg(1, 2, R, F);
		wr(OFF_CMD, 32'h201);
		err(1'b1);
		wr(OFF_CTRL, 32'h1);
		cfg(1, 2, 0, F);
		wr(OFF_CMD, 32'h2);
		err(1'b1);
		cfg(0, 0, R, F);
		wr(OFF_CMD, 32'h102);
		err(1'b1);
		cfg(0, 2, R, F);
		wr(OFF_CMD, 32'h1);
		repeat (600) @(posedge pclk);
		wr(OFF_PCOUNT, 32'ha);
		wr(OFF_DECEL, R);
		wr(OFF_RATE, 32'h7d0);
		wr(OFF_CMD, 32'h2);
		// Pulses already in flight at the takeover edge belong to the old run
		repeat (2) @(posedge pclk);
		s = c0;
		err(1'b0);
		wi(1);
		chk(c0 - s, 32'ha);
		wr(OFF_CTRL, 32'h0);
		rd(OFF_STATUS);
		chk(q & 32'h6, 32'h0);
		s = c1;
		repeat (1000) @(posedge pclk);
		chk(c1, s);
		wr(OFF_CTRL, 32'h1);
		wr(OFF_PCOUNT, 32'h14);
		wr(OFF_CMD, 32'h4);
		cfg(0, 0, R, F);
		s = c0;
		wr(OFF_CMD, 32'h1);
		err(1'b0);
		wi(1);
		chk(c0 - s, 32'h14);
		s = c0;
		wr(OFF_CMD, 32'h1);
		repeat (1000) @(posedge pclk);
		chk(c0, s);
		wr(OFF_CTRL, 32'h3);
		cfg(1, 2, R, F);
		wr(OFF_CMD, 32'h1);
		rd(OFF_STATUS);
		chk(q & 32'h4, 32'h0);
		wr(OFF_CTRL, 32'h1);
		cfg(1, 3, R, F);
		wr(OFF_CMD, 32'h1);
		repeat (300) @(posedge pclk);
		chk({31'h0, dir_out[1]}, 32'h1);
		wr(OFF_TGT_LO, 32'h0);
		wr(OFF_TGT_HI, 32'h0);
		wr(OFF_CMD, 32'h1);
		wr(OFF_TGT_LO, 32'h86a0);
		wr(OFF_TGT_HI, 32'h1);
		wr(OFF_CMD, 32'h1);
		wi(2);
		rd(OFF_FREQ1);
		chk(q, 32'h0);
		cfg(0, 2, R, F);
		wr(OFF_CMD, 32'h10);
		wr(OFF_CMD, 32'h1);
		err(1'b1);
		wr(OFF_CMD, 32'h8);
		stop_test;
	end
endmodule
